// File: common/bdms_cfg.svh
// Constants of the drive-method selector: register map, field positions,
// reset values and timing counts.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
`ifndef BDMS_CFG_SVH
`define BDMS_CFG_SVH

`define BDMS_CLK_HZ          100000000
`define BDMS_HALL_SLOW_S     1
`define BDMS_HALL_SLOW_CYC   (`BDMS_HALL_SLOW_S * `BDMS_CLK_HZ)
`define BDMS_CARRIER_CYC     252

`define BDMS_ADDR_CTRL       8'h00
`define BDMS_ADDR_SPEED      8'h04
`define BDMS_ADDR_STATUS     8'h08

`define BDMS_CTRL_EN_BIT     0
`define BDMS_CTRL_RST        32'h0000_0000
`define BDMS_SPEED_RST       8'h00

`define BDMS_ST_MODE_LSB     0
`define BDMS_ST_FAST_BIT     2
`define BDMS_ST_FWD_BIT      3
`define BDMS_ST_VALID_BIT    4
`define BDMS_ST_LEAD_BIT     5
`define BDMS_ST_SECTOR_LSB   8

`endif

// File: common/bdms_pkg.sv
// Types shared by the drive-method selector and its hall monitor.
// Constants live in bdms_cfg.svh.
package bdms_pkg;

  typedef enum logic [1:0] {
    BDMS_MODE_SQUARE,
    BDMS_MODE_WIDE,
    BDMS_MODE_SINE
  } bdms_mode_t;

  typedef struct packed {
    logic       edge_seen;
    logic       fast;
    logic       fwd;
    logic       valid;
    logic [2:0] sector;
  } bdms_hall_t;

endpackage

// File: hw/bdms_hall_monitor.sv
// Hall monitor: synchronises the three hall inputs, finds the sector,
// the sensed rotation direction and whether the U hall rate exceeds 1 Hz.
// Assumes hall inputs are asynchronous pins; clk is the 100 MHz system clock.
`timescale 1ns/1ps
`include "bdms_cfg.svh"
module bdms_hall_monitor import bdms_pkg::*; #(
  parameter logic [31:0] SLOW_CYC = `BDMS_HALL_SLOW_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] hall_pins,
  output bdms_hall_t      hall
);

  logic [2:0]  sync1_ff;
  logic [2:0]  sync2_ff;
  logic [2:0]  prev_ff;
  logic [31:0] period_ff;
  logic        fast_ff;
  logic        fwd_ff;
  logic [2:0]  sector;
  logic [2:0]  prev_sector;
  logic        hall_edge;
  logic        u_rise;

  // Sector of a {u,v,w} code in forward order; 7 marks all-high or all-low
  function automatic logic [2:0] hall_sector(input logic [2:0] code);
    case (code)
      3'h4:    hall_sector = 3'h0;
      3'h6:    hall_sector = 3'h1;
      3'h2:    hall_sector = 3'h2;
      3'h3:    hall_sector = 3'h3;
      3'h1:    hall_sector = 3'h4;
      3'h5:    hall_sector = 3'h5;
      default: hall_sector = 3'h7;
    endcase
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff  <= 3'h0;
    end else begin
      sync1_ff <= hall_pins;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign sector      = hall_sector(sync2_ff);
  assign prev_sector = hall_sector(prev_ff);
  assign hall_edge   = (sync2_ff != prev_ff);
  assign u_rise      = sync2_ff[2] & ~prev_ff[2];

  // U-phase period; fast while the last period was under one second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period_ff <= 32'h0;
      fast_ff   <= 1'b0;
    end else if (u_rise) begin
      period_ff <= 32'h0;
      fast_ff   <= (period_ff < SLOW_CYC - 32'h1); // R11
    end else if (period_ff >= SLOW_CYC - 32'h1) begin
      fast_ff   <= 1'b0; // R11
    end else begin
      period_ff <= period_ff + 32'h1;
    end
  end

  // Direction from the step between two valid sectors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_ff <= 1'b1;
    end else if (hall_edge && sector != 3'h7 && prev_sector != 3'h7) begin
      fwd_ff <= (sector == ((prev_sector == 3'h5) ? 3'h0 : prev_sector + 3'h1));
    end
  end

  assign hall.edge_seen = hall_edge;
  assign hall.fast      = fast_ff;
  assign hall.fwd       = fwd_ff;
  assign hall.valid     = (sector != 3'h7);
  assign hall.sector    = sector;

endmodule // bdms_hall_monitor

// File: hw/bdms_drive_select.sv
// Drive-method selector: picks sine PWM, wide-angle or square-wave drive
// and produces the square-wave gate pattern, with a Wishbone register port.
// Assumes pins are asynchronous; lead_angle_input is a code on clk.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bdms_cfg.svh"
// How it works
// R1: Forward set, style low, forward rotation above 1 Hz gives sine drive.
// R2: Reverse set, style low, reverse rotation above 1 Hz gives sine drive.
// R3: Forward set, style high, forward rotation above 1 Hz gives wide-angle drive.
// R4: Reverse set, style high, reverse rotation above 1 Hz gives wide-angle drive.
// R5: Matching direction at 1 Hz or less gives square drive, any style.
// R6: Reverse rotation against a forward setting gives square drive, any rate.
// R7: Reverse set, reverse rotation at 1 Hz or less gives square drive.
// R8: Reverse set with forward rotation gives square drive, any style.
// R9: Lead angle is forced off during square-wave drive.
// R10: Square drive PWMs high sides by speed, low sides plain 120 degree.
// R11: Mode is re-evaluated at hall edges and when the rate falls below 1 Hz.
module bdms_drive_select import bdms_pkg::*; #(
  parameter logic [31:0] SLOW_CYC = `BDMS_HALL_SLOW_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        direction_select,
  input  wire logic        style_select,
  input  wire logic        hall_u_plus,
  input  wire logic        hall_v_plus,
  input  wire logic        hall_w_plus,
  input  wire logic [4:0]  lead_angle_input,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [1:0]  drive_mode,
  output logic      [4:0]  lead_angle,
  output logic      [2:0]  gate_high,
  output logic      [2:0]  gate_low
);

  bdms_hall_t  hall;
  bdms_mode_t  mode_ff;
  bdms_mode_t  nxt_mode;
  logic [1:0]  dir_sync_ff;
  logic [1:0]  style_sync_ff;
  logic        slow_prev_ff;
  logic        ctrl_en_ff;
  logic [7:0]  speed_ff;
  logic [7:0]  carrier_ff;
  logic        pwm_on;
  logic [2:0]  hi_pat;
  logic [2:0]  lo_pat;
  logic [31:0] ack_dat_ff;
  logic        ack_ff;
  logic [4:0]  lead_ff;
  logic [2:0]  gate_high_ff;
  logic [2:0]  gate_low_ff;
  logic        wb_req;

  bdms_hall_monitor #(
    .SLOW_CYC (SLOW_CYC)
  ) u_hall (
    .clk       (clk),
    .rst       (rst),
    .hall_pins ({hall_u_plus, hall_v_plus, hall_w_plus}),
    .hall      (hall)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_sync_ff   <= 2'h0;
      style_sync_ff <= 2'h0;
    end else begin
      dir_sync_ff   <= {dir_sync_ff[0], direction_select};
      style_sync_ff <= {style_sync_ff[0], style_select};
    end
  end

  // Drive method from set direction, style, sensed direction and hall rate
  always_comb begin
    if (dir_sync_ff[1] != hall.fwd) begin
      nxt_mode = BDMS_MODE_SQUARE; // R6 R8
    end else if (!hall.fast) begin
      nxt_mode = BDMS_MODE_SQUARE; // R5 R7
    end else if (style_sync_ff[1]) begin
      nxt_mode = BDMS_MODE_WIDE; // R3 R4
    end else begin
      nxt_mode = BDMS_MODE_SINE; // R1 R2
    end
  end

  // Switch only at a hall edge, or when the rate drops out with no edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff      <= BDMS_MODE_SQUARE;
      slow_prev_ff <= 1'b1;
    end else begin
      slow_prev_ff <= ~hall.fast;
      if (hall.edge_seen || (~hall.fast & ~slow_prev_ff)) begin
        mode_ff <= nxt_mode; // R11
      end
    end
  end

  // Lead angle passes only outside square-wave drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lead_ff <= 5'h0;
    end else if (mode_ff == BDMS_MODE_SQUARE) begin
      lead_ff <= 5'h0; // R9
    end else begin
      lead_ff <= lead_angle_input;
    end
  end

  // Triangle-free carrier: ramp of CARRIER_CYC clocks compared with speed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carrier_ff <= 8'h00;
    end else if (carrier_ff == 8'(`BDMS_CARRIER_CYC - 1)) begin
      carrier_ff <= 8'h00;
    end else begin
      carrier_ff <= carrier_ff + 8'h01;
    end
  end

  assign pwm_on = (carrier_ff < speed_ff);

  // 120 degree pattern by sector; reverse drive swaps high and low sides
  always_comb begin
    case (hall.sector)
      3'h0:    begin hi_pat = 3'h4; lo_pat = 3'h2; end
      3'h1:    begin hi_pat = 3'h4; lo_pat = 3'h1; end
      3'h2:    begin hi_pat = 3'h2; lo_pat = 3'h1; end
      3'h3:    begin hi_pat = 3'h2; lo_pat = 3'h4; end
      3'h4:    begin hi_pat = 3'h1; lo_pat = 3'h4; end
      3'h5:    begin hi_pat = 3'h1; lo_pat = 3'h2; end
      default: begin hi_pat = 3'h0; lo_pat = 3'h0; end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_high_ff <= 3'h0;
      gate_low_ff  <= 3'h0;
    end else if (!ctrl_en_ff || !hall.valid || mode_ff != BDMS_MODE_SQUARE) begin
      gate_high_ff <= 3'h0;
      gate_low_ff  <= 3'h0;
    end else if (dir_sync_ff[1]) begin
      gate_high_ff <= pwm_on ? hi_pat : 3'h0; // R10
      gate_low_ff  <= lo_pat; // R10
    end else begin
      gate_high_ff <= pwm_on ? lo_pat : 3'h0; // R10
      gate_low_ff  <= hi_pat; // R10
    end
  end

  // Classic Wishbone slave, one wait state, ack for one cycle
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_en_ff <= 1'(`BDMS_CTRL_RST);
      speed_ff   <= `BDMS_SPEED_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `BDMS_ADDR_CTRL) begin
        ctrl_en_ff <= wb_dat_i[`BDMS_CTRL_EN_BIT];
      end else if (wb_adr_i == `BDMS_ADDR_SPEED) begin
        speed_ff <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_dat_ff <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      ack_dat_ff <= 32'h0;
      if (wb_adr_i == `BDMS_ADDR_CTRL) begin
        ack_dat_ff[`BDMS_CTRL_EN_BIT] <= ctrl_en_ff;
      end else if (wb_adr_i == `BDMS_ADDR_SPEED) begin
        ack_dat_ff[7:0] <= speed_ff;
      end else if (wb_adr_i == `BDMS_ADDR_STATUS) begin
        ack_dat_ff[`BDMS_ST_MODE_LSB +: 2]   <= mode_ff;
        ack_dat_ff[`BDMS_ST_FAST_BIT]        <= hall.fast;
        ack_dat_ff[`BDMS_ST_FWD_BIT]         <= hall.fwd;
        ack_dat_ff[`BDMS_ST_VALID_BIT]       <= hall.valid;
        ack_dat_ff[`BDMS_ST_LEAD_BIT]        <= (mode_ff != BDMS_MODE_SQUARE);
        ack_dat_ff[`BDMS_ST_SECTOR_LSB +: 3] <= hall.sector;
      end
    end
  end

  assign wb_dat_o   = ack_dat_ff;
  assign wb_ack_o   = ack_ff;
  assign drive_mode = mode_ff;
  assign lead_angle = lead_ff;
  assign gate_high  = gate_high_ff;
  assign gate_low   = gate_low_ff;

endmodule // bdms_drive_select

// File: sim/bdms_drive_properties.sv
// Checker of the selector's mode, lead angle, gates and Wishbone answer.
// Assumes it is bound into bdms_drive_select; one clk domain, rst async high.
`timescale 1ns/1ps
module bdms_drive_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [4:0] lead_angle_input,
  input wire logic [1:0] drive_mode,
  input wire logic [4:0] lead_angle,
  input wire logic [2:0] gate_high,
  input wire logic [2:0] gate_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ack_cause_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  lead_off_a: assert property (
    drive_mode == 2'h0 && $past(drive_mode) == 2'h0 |-> lead_angle == 5'h0)
    else $error("lead angle active in square drive");
  lead_follow_a: assert property (
    drive_mode != 2'h0 && $past(drive_mode) != 2'h0 |-> lead_angle == $past(lead_angle_input))
    else $error("lead angle not following input");
  gate_off_a: assert property (
    drive_mode != 2'h0 && $past(drive_mode) != 2'h0 |-> (gate_high | gate_low) == 3'h0)
    else $error("gates driven outside square drive");
  gate_excl_a: assert property (
    (gate_high & gate_low) == 3'h0) else $error("phase on both sides");
  gate_one_a: assert property (
    $onehot0(gate_high) && $onehot0(gate_low)) else $error("two phases on one side");
  mode_legal_a: assert property (
    drive_mode != 2'h3) else $error("illegal drive mode");
  cover property (drive_mode == 2'h2);
  cover property (drive_mode == 2'h1);
  cover property (gate_low != 3'h0);
endmodule // bdms_drive_properties

// File: sim/bdms_hall_model.sv
// Hall sensor model: steps the three hall lines one sector every PER cycles.
// Assumes one clk; the sensor holds its last code while the rotor stands.
`timescale 1ns/1ps
module bdms_hall_model #(
  parameter int PER = 50
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       fwd,
  input  wire logic       bad,
  output logic      [2:0] hall
);
  localparam logic [17:0] SEQ = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  logic [2:0] idx_ff;
  int         cnt_ff;
  // Bad forces the all-low code of a broken sensor
  assign hall = bad ? 3'h0 : SEQ[int'(idx_ff) * 3 +: 3];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_ff <= 3'h0;
      cnt_ff <= 0;
    end else if (run) begin
      cnt_ff <= (cnt_ff == PER - 1) ? 0 : cnt_ff + 1;
      if (cnt_ff == PER - 1)
        idx_ff <= fwd ? ((idx_ff == 3'h5) ? 3'h0 : idx_ff + 3'h1)
                      : ((idx_ff == 3'h0) ? 3'h5 : idx_ff - 3'h1);
    end
  end
endmodule // bdms_hall_model

// File: sim/tb_top.sv
// Testbench: drives pins and Wishbone; the hall model spins the rotor.
// Assumes bdms_drive_select at 100 MHz with SLOW_CYC shortened to 2000.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end
`define WAITC(c) begin for (w = 0; w < 5000 && !(c); w++) @(posedge clk); \
  if (w == 5000) begin fails++; end_sim(); end end
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        dir = 1'b1, style = 1'b0, run = 1'b0, fwd = 1'b1, bad = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd;
  logic [4:0]  la_in = 5'h15;
  logic [2:0]  hall, acc;
  logic [31:0] dat_o;
  logic        ack;
  logic [1:0]  mode;
  logic [4:0]  lead;
  logic [2:0]  gh, gl;
  int          fails = 0, checks_done = 0, w;
  always #5 clk = ~clk;
  bdms_hall_model #(.PER(50)) bdms_hall_model_i (.clk(clk), .rst(rst), .run(run),
    .fwd(fwd), .bad(bad), .hall(hall));
  bdms_drive_select #(.SLOW_CYC(32'd2000)) bdms_drive_select_i (.clk(clk), .rst(rst),
    .direction_select(dir), .style_select(style), .hall_u_plus(hall[2]),
    .hall_v_plus(hall[1]), .hall_w_plus(hall[0]), .lead_angle_input(la_in),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .drive_mode(mode),
    .lead_angle(lead), .gate_high(gh), .gate_low(gl));
  task automatic end_sim();
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (i == 20) begin fails++; end_sim(); end
  endtask
  // Rotor at rest on the first sector, square drive after reset
  task automatic t_regs();
    int n;
    wb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    wb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b1, 8'h04, 32'hFF);
    wb(1'b1, 8'h00, 32'h1);
    // Write without the low byte lane must leave SPEED alone
    sel <= 4'hE;
    wb(1'b1, 8'h04, 32'h55);
    sel <= 4'hF;
    wb(1'b0, 8'h04, 32'h0);
    `CHK("speed", 32'hFF, rd)
    `WAITC(gh === 3'h4)
    `CHK("gate_low", 3'h2, gl)
    `CHK("lead", 5'h0, lead)
    wb(1'b1, 8'h04, 32'h0);
    repeat (3) @(posedge clk);
    acc = 3'h0;
    repeat (260) begin @(posedge clk); acc |= gh; end
    `CHK("pwm_off", 3'h0, acc)
    // Half speed: one full carrier period holds exactly 126 on-cycles
    wb(1'b1, 8'h04, 32'h7E);
    repeat (3) @(posedge clk);
    n = 0;
    repeat (252) begin @(posedge clk); if (gh !== 3'h0) n++; end
    `CHK("pwm_duty", 126, n)
  endtask
  task automatic spin(input logic d, s, f, input logic [1:0] m);
    dir <= d;
    style <= s;
    fwd <= f;
    run <= 1'b1;
    `WAITC(mode === m)
    repeat (700) @(posedge clk);
  endtask
  task automatic stop_chk();
    run <= 1'b0;
    `WAITC(mode === 2'h0)
    `CHK("slow_time", 1'b1, (w > 1500 && w < 2100))
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    spin(1'b1, 1'b0, 1'b1, 2'h2);
    `CHK("mode", 2'h2, mode)
    `CHK("lead", 5'h15, lead)
    wb(1'b0, 8'h08, 32'h0);
    `CHK("status", 2'h2, rd[1:0])
    `CHK("status_flags", 8'h3E, rd[7:0])
    spin(1'b1, 1'b1, 1'b1, 2'h1);
    `CHK("mode", 2'h1, mode)
    spin(1'b1, 1'b1, 1'b0, 2'h0);
    `CHK("mode", 2'h0, mode)
    `CHK("lead", 5'h0, lead)
    spin(1'b0, 1'b1, 1'b0, 2'h1);
    `CHK("mode", 2'h1, mode)
    spin(1'b0, 1'b0, 1'b0, 2'h2);
    `CHK("mode", 2'h2, mode)
    spin(1'b0, 1'b0, 1'b1, 2'h0);
    `CHK("mode", 2'h0, mode)
    spin(1'b0, 1'b0, 1'b0, 2'h2);
    stop_chk();
    spin(1'b1, 1'b1, 1'b1, 2'h1);
    stop_chk();
    bad <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("gates_bad", 3'h0, gh | gl)
    end_sim();
  end
endmodule // tb_top
bind bdms_drive_select bdms_drive_properties bdms_drive_properties_i (.clk, .rst,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .lead_angle_input, .drive_mode, .lead_angle,
  .gate_high, .gate_low);
